// ### core/neutral_protection.sv
// What this block does
// - Two instances of each neutral element
// - Time element uses 3I0, phasor or RMS
// - Reset method: timed ramp or instantaneous clear
// - Block input decays accumulator per reset method
// - Instantaneous element: no delay or definite time
// - Instantaneous operate: 3(|I0| - |I1|/16)
// - Directional trip: magnitude over pickup and direction
// - Separate forward and reverse pickup thresholds
// - Directional operate: 3(|I0| - K|I1|)
// - K forced zero at low positive-sequence current
// - Polarizing by voltage, ground current or both
// - Calculated-current voltage and current comparisons
// - Measured ground mode: voltage polarizing, |IG|
// - Auxiliary voltage divided by three replaces V0
// - Dual mode: either comparator, forward wins
// - No voltage-polarized direction unless polarizing voltage valid
// - No current-polarized direction unless ground polarizing current valid
// - Forward delayed after persistent reverse
`timescale 1ns/1ps
`include "nprot_cfg.svh"
module neutral_protection (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Measurement front-end
    input wire logic meas_valid_i,
    input wire nprot_pkg::mag_t i0_mag_i,
    input wire nprot_pkg::mag_t i0_rms_i,
    input wire nprot_pkg::ang_t i0_ang_i,
    input wire nprot_pkg::mag_t i1_mag_i,
    input wire nprot_pkg::mag_t v0_mag_i,
    input wire nprot_pkg::ang_t v0_ang_i,
    input wire nprot_pkg::mag_t vx_mag_i,
    input wire nprot_pkg::ang_t vx_ang_i,
    input wire nprot_pkg::mag_t ig_mag_i,
    input wire nprot_pkg::ang_t ig_ang_i,
    // Element outputs
    output logic [1:0] toc_pickup_o,
    output logic [1:0] toc_operate_o,
    output logic [1:0] ioc_pickup_o,
    output logic [1:0] ioc_operate_o,
    output logic [1:0] forward_direction_trip_o,
    output logic [1:0] reverse_direction_trip_o
);
    import nprot_pkg::*;

    function automatic logic [3:0] cfg_index(input logic [11:0] a);
        cfg_index = {a[`ELEM_SEL_BIT], a[`WORD_MSB:`WORD_LSB]};
    endfunction : cfg_index

    // 3 x (|I0| - K|I1|), K in 1/256 steps, floored at zero
    function automatic iop_t restrained(input mag_t i0, input mag_t i1, input logic [7:0] k);
        logic [23:0] prod;
        logic [15:0] diff;
        prod = 24'(k) * 24'(i1);
        diff = (i0 > prod[`K_SHIFT +: 16]) ? i0 - prod[`K_SHIFT +: 16] : '0;
        restrained = 18'({diff, 1'b0}) + 18'(diff);
    endfunction : restrained

    // APB register file
    logic [31:0] cfg_reg [0:`CFG_WORDS-1];
    logic [31:0] cfg_next [0:`CFG_WORDS-1];
    logic [31:0] prdata_reg, prdata_next, status_word;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic cfg_hit, status_hit, access;

    always_comb begin
        for (int w = 0; w < `CFG_WORDS; w++) begin
            cfg_next[w] = cfg_reg[w];
        end
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        cfg_hit = (paddr_i[11:`CFG_HI_LSB] == '0) && (paddr_i[1:0] == 2'h0);
        status_hit = (paddr_i == `OFS_STATUS);
        access = psel_i && penable_i;
        pready_next = access && !pready_reg;
        if (access && !pready_reg) begin
            pslverr_next = !(cfg_hit || status_hit);
            if (pwrite_i || !(cfg_hit || status_hit)) begin
                prdata_next = '0;
            end else begin
                prdata_next = status_hit ? status_word : cfg_reg[cfg_index(paddr_i)];
            end
        end
        if (access && pready_reg && pwrite_i && cfg_hit) begin
            cfg_next[cfg_index(paddr_i)] = pwdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int w = 0; w < `CFG_WORDS; w++) begin
                cfg_reg[w] <= '0;
            end
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            for (int w = 0; w < `CFG_WORDS; w++) begin
                cfg_reg[w] <= cfg_next[w];
            end
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;

    // Shared front-end derived quantities
    mag_t vx_third, ig_third;
    assign vx_third = vx_mag_i / `THIRD_DIV;
    assign ig_third = ig_mag_i / `THIRD_DIV;

    logic [5:0] elem_status [0:1];
    assign status_word = {16'h0000, 2'h0, elem_status[1], 2'h0, elem_status[0]};

    genvar e;
    generate
        for (e = 0; e < 2; e++) begin : g_elem
            logic [31:0] toc_cfg, toc_dly, ioc_cfg, ioc_dly;
            logic [31:0] dir_fwd, dir_rev, dir_cfg, dir_zoff;
            iop_t toc_iop, ioc_iop, dir_iop;
            mag_t vpol_mag, opa_mag;
            ang_t vpol_ang, opa_ang;
            logic mig, use_v, use_i, v_valid, i_valid;
            logic vf, vr, cf, cr, fwd_raw, rev_raw, fwd_dir, rev_load;
            logic [7:0] k_eff;
            logic [1:0] mode;

            assign toc_cfg = cfg_reg[{1'(e), `W_TOC_CFG}];
            assign toc_dly = cfg_reg[{1'(e), `W_TOC_DLY}];
            assign ioc_cfg = cfg_reg[{1'(e), `W_IOC_CFG}];
            assign ioc_dly = cfg_reg[{1'(e), `W_IOC_DLY}];
            assign dir_fwd = cfg_reg[{1'(e), `W_DIR_FWD}];
            assign dir_rev = cfg_reg[{1'(e), `W_DIR_REV}];
            assign dir_cfg = cfg_reg[{1'(e), `W_DIR_CFG}];
            assign dir_zoff = cfg_reg[{1'(e), `W_DIR_ZOFF}];

            // Time overcurrent
            assign toc_iop = restrained(toc_cfg[`F_RMS] ? i0_rms_i : i0_mag_i, '0, '0);

            toc_element u_toc (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .step_i(meas_valid_i),
                .iop_i(toc_iop),
                .enable_i(toc_cfg[`F_EN]),
                .block_i(toc_cfg[`F_BLOCK]),
                .inst_reset_i(toc_cfg[`F_INST]),
                .pickup_i(toc_cfg[`F_PU_MSB:0]),
                .delay_i(toc_dly[`F_DLY_MSB:0]),
                .pickup_o(toc_pickup_o[e]),
                .operate_o(toc_operate_o[e])
            );

            // Instantaneous overcurrent with optional definite time
            dly_t ioc_cnt_reg, ioc_cnt_next;
            logic ioc_pu_reg, ioc_pu_next, ioc_op_reg, ioc_op_next, ioc_above;

            assign ioc_iop = restrained(i0_mag_i, i1_mag_i, `IOC_K);

            always_comb begin
                ioc_cnt_next = ioc_cnt_reg;
                ioc_pu_next = ioc_pu_reg;
                ioc_op_next = ioc_op_reg;
                ioc_above = ioc_cfg[`F_EN] && !ioc_cfg[`F_BLOCK] &&
                    (ioc_iop > ioc_cfg[`F_PU_MSB:0]);
                if (meas_valid_i) begin
                    if (ioc_above) begin
                        ioc_cnt_next = (ioc_cnt_reg == '1) ? ioc_cnt_reg : ioc_cnt_reg + 16'h0001;
                    end else begin
                        ioc_cnt_next = '0;
                    end
                    ioc_pu_next = ioc_above;
                    ioc_op_next = ioc_above && (ioc_cnt_reg >= ioc_dly[`F_DLY_MSB:0]);
                end
            end

            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    ioc_cnt_reg <= '0;
                    ioc_pu_reg <= 1'b0;
                    ioc_op_reg <= 1'b0;
                end else begin
                    ioc_cnt_reg <= ioc_cnt_next;
                    ioc_pu_reg <= ioc_pu_next;
                    ioc_op_reg <= ioc_op_next;
                end
            end

            assign ioc_pickup_o[e] = ioc_pu_reg;
            assign ioc_operate_o[e] = ioc_op_reg;

            // Directional overcurrent
            assign mig = dir_cfg[`F_MIG];
            assign mode = mig ? POL_VOLT : dir_cfg[`F_MODE_MSB:`F_MODE_LSB];
            assign use_v = mode[0];
            assign use_i = mode[1];
            assign k_eff = (i1_mag_i <= `I1_LOW_LIMIT) ? '0 : dir_cfg[`F_K_MSB:`F_K_LSB];
            assign dir_iop = mig ? iop_t'(ig_mag_i) : restrained(i0_mag_i, i1_mag_i, k_eff);
            assign vpol_mag = dir_cfg[`F_VX] ? vx_third : v0_mag_i;
            assign vpol_ang = dir_cfg[`F_VX] ? vx_ang_i : v0_ang_i;
            assign opa_mag = mig ? ig_third : i0_mag_i;
            assign opa_ang = mig ? ig_ang_i : i0_ang_i;
            assign v_valid = vpol_mag > `VPOL_MIN;
            assign i_valid = ig_mag_i > `IPOL_MIN;

            dir_compare u_vcmp (
                .vpol_mag_i(vpol_mag),
                .vpol_ang_i(vpol_ang),
                .op_mag_i(opa_mag),
                .op_ang_i(opa_ang),
                .char_ang_i(dir_cfg[`F_ECA_MSB:`F_ECA_LSB]),
                .zoff_i(dir_zoff[`F_Z_MSB:0]),
                .fwd_o(vf),
                .rev_o(vr)
            );

            // Ground current against I0: fed as a negated voltage with no offset
            dir_compare u_icmp (
                .vpol_mag_i(ig_mag_i),
                .vpol_ang_i(ig_ang_i + `HALF_TURN),
                .op_mag_i(i0_mag_i),
                .op_ang_i(i0_ang_i),
                .char_ang_i('0),
                .zoff_i('0),
                .fwd_o(cf),
                .rev_o(cr)
            );

            assign fwd_raw = (use_v && v_valid && vf) || (use_i && i_valid && cf);
            assign rev_raw = ((use_v && v_valid && vr) || (use_i && i_valid && cr)) && !fwd_raw;

            // Current reversal guard
            logic [7:0] rev_cnt_reg, rev_cnt_next, hold_reg, hold_next;
            logic fwd_trip_reg, fwd_trip_next, rev_trip_reg, rev_trip_next;

            assign rev_load = !rev_raw && (rev_cnt_reg >= `REV_PERSIST_STEPS);
            assign fwd_dir = fwd_raw && !rev_load && (hold_reg == '0);

            always_comb begin
                rev_cnt_next = rev_cnt_reg;
                hold_next = hold_reg;
                fwd_trip_next = fwd_trip_reg;
                rev_trip_next = rev_trip_reg;
                if (meas_valid_i) begin
                    if (rev_raw) begin
                        rev_cnt_next = (rev_cnt_reg == '1) ? rev_cnt_reg : rev_cnt_reg + 8'h01;
                    end else begin
                        rev_cnt_next = '0;
                    end
                    if (rev_load) begin
                        hold_next = `FWD_DELAY_STEPS - 8'h01;
                    end else if (hold_reg != '0) begin
                        hold_next = hold_reg - 8'h01;
                    end
                    fwd_trip_next = dir_fwd[`F_EN] && fwd_dir &&
                        (dir_iop > dir_fwd[`F_PU_MSB:0]);
                    rev_trip_next = dir_fwd[`F_EN] && rev_raw &&
                        (dir_iop > dir_rev[`F_PU_MSB:0]);
                end
            end

            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    rev_cnt_reg <= '0;
                    hold_reg <= '0;
                    fwd_trip_reg <= 1'b0;
                    rev_trip_reg <= 1'b0;
                end else begin
                    rev_cnt_reg <= rev_cnt_next;
                    hold_reg <= hold_next;
                    fwd_trip_reg <= fwd_trip_next;
                    rev_trip_reg <= rev_trip_next;
                end
            end

            assign forward_direction_trip_o[e] = fwd_trip_reg;
            assign reverse_direction_trip_o[e] = rev_trip_reg;
            assign elem_status[e] = {rev_trip_reg, fwd_trip_reg, ioc_op_reg, ioc_pu_reg,
                toc_operate_o[e], toc_pickup_o[e]};
        end
    endgenerate
endmodule : neutral_protection

// ### inc/nprot_cfg.svh
`ifndef NPROT_CFG_SVH
`define NPROT_CFG_SVH

// Register map: one 8-word window per element set, status word after them
`define ELEM_SEL_BIT 5
`define WORD_LSB 2
`define WORD_MSB 4
`define CFG_HI_LSB 6
`define OFS_STATUS 12'h040
`define W_TOC_CFG 3'h0
`define W_TOC_DLY 3'h1
`define W_IOC_CFG 3'h2
`define W_IOC_DLY 3'h3
`define W_DIR_FWD 3'h4
`define W_DIR_REV 3'h5
`define W_DIR_CFG 3'h6
`define W_DIR_ZOFF 3'h7
`define CFG_WORDS 16
`define STATUS_STRIDE 8

// Field positions
`define F_PU_MSB 17
`define F_DLY_MSB 15
`define F_EN 24
`define F_RMS 25
`define F_INST 26
`define F_BLOCK 27
`define F_MODE_MSB 1
`define F_MODE_LSB 0
`define F_VX 2
`define F_MIG 3
`define F_K_MSB 15
`define F_K_LSB 8
`define F_ECA_MSB 31
`define F_ECA_LSB 16
`define F_Z_MSB 15

// Magnitudes are Q4.12 per unit, angles are 16-bit fractions of a turn
`define IOC_K 8'h10
`define K_SHIFT 8
`define Z_SHIFT 8
`define I1_LOW_LIMIT 16'h0CCC
`define VPOL_MIN 16'h0051
`define IPOL_MIN 16'h00CC
`define THIRD_DIV 16'h0003
`define HALF_TURN 16'h8000
`define QUARTER_TURN 16'h4000

// Current reversal timing, in quarters of a power-system cycle
`define STEPS_PER_PSC 16
`define REV_PERSIST_QTR 5
`define FWD_DELAY_QTR 6
`define REV_PERSIST_STEPS 8'((`STEPS_PER_PSC * `REV_PERSIST_QTR + 3) / 4)
`define FWD_DELAY_STEPS 8'((`STEPS_PER_PSC * `FWD_DELAY_QTR) / 4)

`endif

// ### inc/nprot_pkg.sv
package nprot_pkg;
    typedef logic [15:0] mag_t;
    typedef logic [15:0] ang_t;
    typedef logic [17:0] iop_t;
    typedef logic [15:0] dly_t;
    typedef enum logic [1:0] {
        POL_NONE = 2'h0,
        POL_VOLT = 2'h1,
        POL_CURR = 2'h2,
        POL_DUAL = 2'h3
    } pol_mode_t;
endpackage : nprot_pkg

// ### core/dir_compare.sv
`timescale 1ns/1ps
`include "nprot_cfg.svh"
// Phase comparator: sign of the dot product of (-V + Z*I at ref) and I at ref
module dir_compare (
    // Polarizing voltage
    input wire nprot_pkg::mag_t vpol_mag_i,
    input wire nprot_pkg::ang_t vpol_ang_i,
    // Operating current and settings
    input wire nprot_pkg::mag_t op_mag_i,
    input wire nprot_pkg::ang_t op_ang_i,
    input wire nprot_pkg::ang_t char_ang_i,
    input wire logic [15:0] zoff_i,
    // Result
    output logic fwd_o,
    output logic rev_o
);
    import nprot_pkg::*;

    // Parabolic sine, Q2.14, a few percent error which only bends the boundary
    function automatic logic signed [15:0] sin_q14(input logic [15:0] a);
        logic [14:0] x;
        logic [30:0] p;
        logic [15:0] m;
        x = a[14:0];
        p = 31'(x) * 31'(17'h08000 - {2'h0, x});
        m = p[29:14];
        sin_q14 = a[15] ? -$signed(m) : $signed(m);
    endfunction : sin_q14

    logic [15:0] ref_ang;
    logic [31:0] z_prod;
    logic signed [24:0] zi_mag;
    logic signed [42:0] px, py;
    logic signed [15:0] ox, oy, vc, vs;
    logic signed [63:0] dot;

    always_comb begin
        ref_ang = op_ang_i + char_ang_i;
        z_prod = 32'(zoff_i) * 32'(op_mag_i);
        zi_mag = $signed({1'b0, z_prod[`Z_SHIFT +: 24]});
        ox = sin_q14(ref_ang + `QUARTER_TURN);
        oy = sin_q14(ref_ang);
        vc = sin_q14(vpol_ang_i + `QUARTER_TURN);
        vs = sin_q14(vpol_ang_i);
        px = 43'(zi_mag) * 43'(ox) - 43'($signed({1'b0, vpol_mag_i})) * 43'(vc);
        py = 43'(zi_mag) * 43'(oy) - 43'($signed({1'b0, vpol_mag_i})) * 43'(vs);
        dot = 64'(px) * 64'(ox) + 64'(py) * 64'(oy);
        fwd_o = dot > 0;
        rev_o = dot < 0;
    end
endmodule : dir_compare

// ### core/toc_element.sv
`timescale 1ns/1ps
`include "nprot_cfg.svh"
// Time accumulator with timed or instantaneous reset, stepped per strobe
module toc_element (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Processing step
    input wire logic step_i,
    input wire nprot_pkg::iop_t iop_i,
    // Settings
    input wire logic enable_i,
    input wire logic block_i,
    input wire logic inst_reset_i,
    input wire nprot_pkg::iop_t pickup_i,
    input wire nprot_pkg::dly_t delay_i,
    // Results
    output logic pickup_o,
    output logic operate_o
);
    import nprot_pkg::*;

    dly_t acc_reg, acc_next;
    logic pickup_reg, pickup_next, operate_reg, operate_next;
    logic above;

    always_comb begin
        acc_next = acc_reg;
        pickup_next = pickup_reg;
        operate_next = operate_reg;
        above = enable_i && !block_i && (iop_i > pickup_i);
        if (step_i) begin
            if (above) begin
                acc_next = (acc_reg == '1) ? acc_reg : acc_reg + 16'h0001;
            end else if (inst_reset_i) begin
                acc_next = '0;
            end else if (acc_reg != '0) begin
                acc_next = acc_reg - 16'h0001;
            end
            pickup_next = above;
            operate_next = above && (acc_reg >= delay_i);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_reg <= '0;
            pickup_reg <= 1'b0;
            operate_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            pickup_reg <= pickup_next;
            operate_reg <= operate_next;
        end
    end

    assign pickup_o = pickup_reg;
    assign operate_o = operate_reg;
endmodule : toc_element

// ### sim/neutral_protection_properties.sv
`timescale 1ns/1ps
module neutral_protection_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Measurement front-end
    input wire logic meas_valid_i,
    input wire nprot_pkg::mag_t i0_mag_i,
    input wire nprot_pkg::mag_t i0_rms_i,
    input wire nprot_pkg::mag_t v0_mag_i,
    input wire nprot_pkg::mag_t vx_mag_i,
    input wire nprot_pkg::mag_t ig_mag_i,
    // Element outputs
    input wire logic [1:0] toc_pickup_o,
    input wire logic [1:0] toc_operate_o,
    input wire logic [1:0] ioc_pickup_o,
    input wire logic [1:0] ioc_operate_o,
    input wire logic [1:0] forward_direction_trip_o,
    input wire logic [1:0] reverse_direction_trip_o
);
    import nprot_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic [11:0] outs;
    logic [1:0] both_dir;
    assign outs = {toc_pickup_o, toc_operate_o, ioc_pickup_o, ioc_operate_o,
        forward_direction_trip_o, reverse_direction_trip_o};
    assign both_dir = forward_direction_trip_o & reverse_direction_trip_o;

    a_ready_one_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_slverr_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    a_outs_hold_idle: assert property (!meas_valid_i |=> $stable(outs))
        else $error("element outputs changed without strobe");
    a_fwd_wins_dual: assert property (both_dir == 2'h0)
        else $error("forward and reverse together");
    a_no_pol_nodir: assert property (meas_valid_i && v0_mag_i <= 16'h0051
        && vx_mag_i <= 16'h0051 && ig_mag_i <= 16'h00CC
        |=> forward_direction_trip_o == 2'h0 && reverse_direction_trip_o == 2'h0)
        else $error("direction without valid polarizing");
    a_zero_current: assert property (meas_valid_i && i0_mag_i == 16'h0000
        && i0_rms_i == 16'h0000 |=> ioc_pickup_o == 2'h0 && toc_pickup_o == 2'h0)
        else $error("pickup with zero current");
    a_toc_op_pickup: assert property ((toc_operate_o & ~toc_pickup_o) == 2'h0)
        else $error("time element operates without pickup");
    a_ioc_op_pickup: assert property ((ioc_operate_o & ~ioc_pickup_o) == 2'h0)
        else $error("instantaneous element operates without pickup");

    c_toc_op: cover property (toc_operate_o[0]);
    c_ioc_op: cover property (ioc_operate_o[1]);
    c_fwd_e1: cover property ($rose(forward_direction_trip_o[1]));
endmodule : neutral_protection_properties

bind neutral_protection neutral_protection_properties i_neutral_protection_properties (
    .clk_i, .resetn_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .meas_valid_i,
    .i0_mag_i, .i0_rms_i, .v0_mag_i, .vx_mag_i, .ig_mag_i, .toc_pickup_o,
    .toc_operate_o, .ioc_pickup_o, .ioc_operate_o, .forward_direction_trip_o,
    .reverse_direction_trip_o
);

// ### sim/fe_model.sv
`timescale 1ns/1ps
module fe_model #(
    parameter int GAP = 3
) (
    // Clock
    input wire logic clk_i,
    // Sequence quantities
    output logic meas_valid_o,
    output nprot_pkg::mag_t i0_mag_o,
    output nprot_pkg::mag_t i0_rms_o,
    output nprot_pkg::ang_t i0_ang_o,
    output nprot_pkg::mag_t i1_mag_o,
    output nprot_pkg::mag_t v0_mag_o,
    output nprot_pkg::ang_t v0_ang_o,
    output nprot_pkg::mag_t vx_mag_o,
    output nprot_pkg::ang_t vx_ang_o,
    output nprot_pkg::mag_t ig_mag_o,
    output nprot_pkg::ang_t ig_ang_o
);
    import nprot_pkg::*;
    logic [15:0] i0, rms, i0a, i1, v0, v0a, vx, vxa, ig, iga;
    logic [159:0] pins;
    assign {i0_mag_o, i0_rms_o, i0_ang_o, i1_mag_o, v0_mag_o, v0_ang_o,
        vx_mag_o, vx_ang_o, ig_mag_o, ig_ang_o} = pins;
    initial begin
        meas_valid_o = 1'b0;
        pins = '0;
        {i0, rms, i0a, i1, v0, v0a, vx, vxa, ig, iga} = '0;
    end

    // One set per processing cycle; between strobes the pins carry the inverted set
    task automatic step(input int n);
        repeat (n) begin
            repeat (GAP) @(posedge clk_i);
            meas_valid_o <= 1'b1;
            pins <= {i0, rms, i0a, i1, v0, v0a, vx, vxa, ig, iga};
            @(posedge clk_i);
            meas_valid_o <= 1'b0;
            pins <= ~{i0, rms, i0a, i1, v0, v0a, vx, vxa, ig, iga};
        end
    endtask : step
endmodule : fe_model

// ### sim/test_neutral_protection.sv
`timescale 1ns/1ps
`include "nprot_cfg.svh"
module test_neutral_protection;
    import nprot_pkg::*;
    logic clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, meas_valid_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic er;
    mag_t i0_mag_i, i0_rms_i, i1_mag_i, v0_mag_i, vx_mag_i, ig_mag_i;
    ang_t i0_ang_i, v0_ang_i, vx_ang_i, ig_ang_i;
    logic [1:0] toc_pickup_o, toc_operate_o, ioc_pickup_o, ioc_operate_o;
    logic [1:0] forward_direction_trip_o, reverse_direction_trip_o;
    logic [11:0] outs;
    int failures, n_compared;
    // Bit pairs: toc pu, toc op, ioc pu, ioc op, forward, reverse (element 0 low)
    assign outs = {reverse_direction_trip_o, forward_direction_trip_o, ioc_operate_o,
        ioc_pickup_o, toc_operate_o, toc_pickup_o};

    neutral_protection i_neutral_protection (
        .clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .meas_valid_i, .i0_mag_i, .i0_rms_i,
        .i0_ang_i, .i1_mag_i, .v0_mag_i, .v0_ang_i, .vx_mag_i, .vx_ang_i, .ig_mag_i,
        .ig_ang_i, .toc_pickup_o, .toc_operate_o, .ioc_pickup_o, .ioc_operate_o,
        .forward_direction_trip_o, .reverse_direction_trip_o
    );
    fe_model i_fe_model (
        .clk_i, .meas_valid_o(meas_valid_i), .i0_mag_o(i0_mag_i), .i0_rms_o(i0_rms_i),
        .i0_ang_o(i0_ang_i), .i1_mag_o(i1_mag_i), .v0_mag_o(v0_mag_i),
        .v0_ang_o(v0_ang_i), .vx_mag_o(vx_mag_i), .vx_ang_o(vx_ang_i),
        .ig_mag_o(ig_mag_i), .ig_ang_o(ig_ang_i)
    );

    initial clk_i = 1'b0;
    always #20 clk_i = ~clk_i;

    task automatic final_report;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    function automatic logic [11:0] ra(input int e, input logic [2:0] w);
        return 12'(e * 32 + int'(w) * 4);
    endfunction : ra

    task automatic stp(input int n);
        i_fe_model.step(n);
        @(negedge clk_i);
    endtask : stp

    // Compare the masked output bits
    task automatic oc(input logic [11:0] m, input logic [11:0] exp);
        chk({20'h0, outs & m}, {20'h0, exp});
    endtask : oc

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        final_report();
    end

    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        resetn_i = 1'b0;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        apb(0, `OFS_STATUS, 0);
        chk(rd, 32'h0);
        apb(0, ra(0, `W_TOC_CFG), 0);
        chk(rd, 32'h0);
        apb(0, 12'h044, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1, ra(1, `W_DIR_CFG), 32'h1234_4003);
        apb(0, ra(1, `W_DIR_CFG), 0);
        chk(rd, 32'h1234_4003);
        apb(1, ra(0, `W_TOC_CFG), 32'h0100_3000);
        apb(1, ra(0, `W_TOC_DLY), 32'h3);
        i_fe_model.i0 = 16'h1100;
        i_fe_model.rms = 16'h0100;
        stp(3);
        oc(12'h005, 12'h001);
        stp(1);
        oc(12'h005, 12'h005);
        apb(0, `OFS_STATUS, 0);
        chk(rd, 32'h3);
        i_fe_model.i0 = 16'h0100;
        stp(1);
        oc(12'h005, 12'h000);
        i_fe_model.i0 = 16'h1100;
        stp(1);
        oc(12'h005, 12'h005);
        apb(1, ra(0, `W_TOC_CFG), 32'h0D00_3000);
        stp(1);
        oc(12'h005, 12'h000);
        apb(1, ra(0, `W_TOC_CFG), 32'h0500_3000);
        stp(1);
        oc(12'h005, 12'h001);
        apb(1, ra(0, `W_TOC_CFG), 32'h0300_3000);
        i_fe_model.i0 = 16'h0100;
        i_fe_model.rms = 16'h1100;
        stp(1);
        oc(12'h001, 12'h001);
        apb(1, ra(1, `W_IOC_CFG), 32'h0100_3000);
        i_fe_model.i0 = 16'h1100;
        i_fe_model.i1 = 16'h1000;
        stp(1);
        oc(12'h0A0, 12'h000);
        i_fe_model.i1 = 16'h0F00;
        stp(1);
        oc(12'h0A0, 12'h0A0);
        apb(1, ra(1, `W_IOC_DLY), 32'h1);
        i_fe_model.i1 = 16'h1000;
        stp(1);
        i_fe_model.i1 = 16'h0F00;
        stp(1);
        oc(12'h0A0, 12'h020);
        stp(1);
        oc(12'h0A0, 12'h0A0);
        apb(1, ra(0, `W_DIR_FWD), 32'h0100_2400);
        apb(1, ra(0, `W_DIR_REV), 32'h0000_3000);
        apb(1, ra(0, `W_DIR_CFG), 32'h0000_4001);
        i_fe_model.i0 = 16'h1000;
        i_fe_model.i1 = 16'h1000;
        i_fe_model.v0 = 16'h1000;
        i_fe_model.v0a = 16'h8000;
        stp(1);
        oc(12'h500, 12'h000);
        i_fe_model.i1 = 16'h0CCC;
        stp(1);
        oc(12'h500, 12'h100);
        i_fe_model.v0a = 16'h0000;
        stp(1);
        oc(12'h500, 12'h000);
        i_fe_model.i0 = 16'h1100;
        stp(1);
        oc(12'h500, 12'h400);
        i_fe_model.v0 = 16'h0051;
        stp(1);
        oc(12'h500, 12'h000);
        apb(1, ra(0, `W_DIR_CFG), 32'h0000_4005);
        i_fe_model.vx = 16'h1000;
        i_fe_model.vxa = 16'h8000;
        stp(1);
        oc(12'h500, 12'h100);
        apb(1, ra(0, `W_DIR_CFG), 32'h0000_4002);
        i_fe_model.ig = 16'h1000;
        stp(1);
        oc(12'h500, 12'h100);
        i_fe_model.iga = 16'h8000;
        stp(1);
        oc(12'h500, 12'h400);
        i_fe_model.ig = 16'h00CC;
        stp(1);
        oc(12'h500, 12'h000);
        apb(1, ra(0, `W_DIR_CFG), 32'h0000_4003);
        {i_fe_model.v0, i_fe_model.ig, i_fe_model.iga} = {16'h1000, 16'h1000, 16'h0};
        stp(1);
        oc(12'h500, 12'h100);
        apb(1, ra(0, `W_DIR_CFG), 32'h0000_4000);
        stp(1);
        oc(12'h500, 12'h000);
        apb(1, ra(0, `W_DIR_CFG), 32'h0000_400B);
        {i_fe_model.i0, i_fe_model.rms, i_fe_model.ig} = {16'h0, 16'h0, 16'h3000};
        i_fe_model.v0a = 16'h8000;
        stp(1);
        oc(12'h535, 12'h100);
        apb(1, ra(1, `W_DIR_FWD), 32'h0100_0800);
        apb(1, ra(1, `W_DIR_REV), 32'h0000_0800);
        apb(1, ra(1, `W_DIR_CFG), 32'h0000_0001);
        {i_fe_model.i0, i_fe_model.v0a} = {16'h1000, 16'h0};
        stp(20);
        oc(12'hA00, 12'h800);
        i_fe_model.v0a = 16'h8000;
        stp(24);
        oc(12'hA00, 12'h000);
        stp(1);
        oc(12'hA00, 12'h200);
        final_report();
    end
endmodule : test_neutral_protection
